// [hw/synth_pll_cfg_pkg.sv]
// Constants and types for the PLL configuration register bank
package synth_pll_cfg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_B_SET0_BYTE0 = 8'h28;
  localparam logic [7:0] IDX_B_SET0_BYTE1 = 8'h29;
  localparam logic [7:0] IDX_B_SET0_BYTE2 = 8'h2A;
  localparam logic [7:0] IDX_B_SET0_BYTE3 = 8'h2B;
  localparam logic [7:0] IDX_B_SET1_BYTE0 = 8'h2C;
  localparam logic [7:0] IDX_B_SET1_BYTE1 = 8'h2D;
  localparam logic [7:0] IDX_B_SET1_BYTE2 = 8'h2E;
  localparam logic [7:0] IDX_B_SET1_BYTE3 = 8'h2F;
  localparam logic [7:0] IDX_C_SPREAD0    = 8'h30;
  localparam logic [7:0] IDX_C_SPREAD1    = 8'h31;
  localparam logic [7:0] IDX_C_SPREAD2    = 8'h32;
  localparam logic [7:0] IDX_C_FREQ_SEL   = 8'h33;
  // Own register: spread direction in bit 0
  localparam logic [7:0] IDX_C_DIRECTION  = 8'h36;
  // Own register: read-only status of the active setting
  localparam logic [7:0] IDX_STATUS       = 8'h3F;
  // Host writes are only safe up to this index
  localparam logic [7:0] IDX_WRITE_LIMIT  = 8'h40;

  // Word field positions inside the 32-bit packed word (bits 31:0 used)
  localparam int N_MSB = 31;
  localparam int N_LSB = 20;
  localparam int R_MSB = 19;
  localparam int R_LSB = 11;
  localparam int Q_MSB = 10;
  localparam int Q_LSB = 5;
  localparam int P_MSB = 4;
  localparam int P_LSB = 2;
  localparam int BAND_MSB = 1;
  localparam int BAND_LSB = 0;

  // Field reset values
  localparam logic [11:0] N_RESET    = 12'h004;
  localparam logic [8:0]  R_RESET    = 9'h000;
  localparam logic [5:0]  Q_RESET    = 6'h10;
  localparam logic [2:0]  P_RESET    = 3'h2;
  localparam logic [1:0]  BAND_RESET = 2'h0;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // Band encodings and boundaries in MHz
  localparam int BAND_EDGE1_MHZ = 125;
  localparam int BAND_EDGE2_MHZ = 150;
  localparam int BAND_EDGE3_MHZ = 175;
  localparam logic [1:0] BAND_LOW  = 2'h0;
  localparam logic [1:0] BAND_MID1 = 2'h1;
  localparam logic [1:0] BAND_MID2 = 2'h2;
  localparam logic [1:0] BAND_HIGH = 2'h3;

  // Spread code and amount in hundredths of a percent
  localparam logic [2:0] SPREAD_OFF = 3'h0;

  // Bus answer for a read of an unmapped index
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Bus access state
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_t;

  // Spread amount in hundredths of a percent
  function automatic logic [7:0] spread_hundredths(input logic [2:0] code);
    logic [7:0] v;
    v = 8'h00;
    case (code)
      3'h1: v = 8'h19;
      3'h2: v = 8'h32;
      3'h3: v = 8'h4B;
      3'h4: v = 8'h64;
      3'h5: v = 8'h7D;
      3'h6: v = 8'h96;
      3'h7: v = 8'hC8;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Band code for an oscillator frequency in MHz
  function automatic logic [1:0] band_for_mhz(input int mhz);
    logic [1:0] b;
    if (mhz < BAND_EDGE1_MHZ) b = BAND_LOW;
    else if (mhz < BAND_EDGE2_MHZ) b = BAND_MID1;
    else if (mhz < BAND_EDGE3_MHZ) b = BAND_MID2;
    else b = BAND_HIGH;
    return b;
  endfunction

endpackage

// [hw/pin_sync.sv]
// Two-flop synchroniser for the control-select pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pin levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;   // First stage, read only by second
  logic [WIDTH-1:0] sync_q;   // Second stage
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  // Register stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// [hw/word_unpack.sv]
// Splits a packed multiplier/divider word into its fields
`timescale 1ns/1ps
module word_unpack (
  // Packed bytes, first byte holds the most significant bits
  input  wire logic [31:0] word_i,
  // Fields
  output logic      [11:0] feedback_count_o,
  output logic      [8:0]  remainder_o,
  output logic      [5:0]  quotient_o,
  output logic      [2:0]  prescale_o,
  output logic      [1:0]  osc_band_o
);

  // Field extraction
  always_comb begin
    feedback_count_o = word_i[synth_pll_cfg_pkg::N_MSB:synth_pll_cfg_pkg::N_LSB];
    remainder_o      = word_i[synth_pll_cfg_pkg::R_MSB:synth_pll_cfg_pkg::R_LSB];
    quotient_o       = word_i[synth_pll_cfg_pkg::Q_MSB:synth_pll_cfg_pkg::Q_LSB];
    prescale_o       = word_i[synth_pll_cfg_pkg::P_MSB:synth_pll_cfg_pkg::P_LSB];
    osc_band_o       = word_i[synth_pll_cfg_pkg::BAND_MSB:synth_pll_cfg_pkg::BAND_LSB];
  end

endmodule

// [hw/synth_pll_config_regs.sv]
// Configuration register bank for the second and third PLL
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module synth_pll_config_regs (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  // Avalon-MM slave
  input  wire logic [9:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Control select pins
  input  wire logic        CTRL_SELECT_PIN0_I,
  input  wire logic        CTRL_SELECT_PIN1_I,
  input  wire logic        CTRL_SELECT_PIN2_I,
  // Second PLL active configuration
  output logic      [11:0] SYNTH_B_FEEDBACK_COUNT_O,
  output logic      [8:0]  SYNTH_B_REMAINDER_O,
  output logic      [5:0]  SYNTH_B_QUOTIENT_O,
  output logic      [2:0]  SYNTH_B_PRESCALE_O,
  output logic      [1:0]  SYNTH_B_OSC_BAND_O,
  // Third PLL active configuration
  output logic      [2:0]  SYNTH_C_SPREAD_AMOUNT_O,
  output logic      [7:0]  SYNTH_C_SPREAD_HUNDREDTHS_O,
  output logic             SYNTH_C_SPREAD_ON_O,
  output logic             SYNTH_C_SPREAD_DIRECTION_O,
  output logic             SYNTH_C_FREQ_CHOICE_O
);

  // Register storage
  logic [7:0]  set0_q [4];          // Set zero word bytes, 28h first
  logic [7:0]  set0_d [4];
  logic [7:0]  set1_q [4];          // Set one word bytes, 2Ch first
  logic [7:0]  set1_d [4];
  logic [23:0] spread_q;            // Eight 3-bit spread amounts
  logic [23:0] spread_d;
  logic [7:0]  freq_sel_q;          // Per-setting set choice
  logic [7:0]  freq_sel_d;
  logic        direction_q;         // Spread direction
  logic        direction_d;

  // Bus state
  synth_pll_cfg_pkg::bus_state_t state_q;
  synth_pll_cfg_pkg::bus_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wait_q;
  logic        wait_d;
  logic [7:0]  idx;                 // Word index of the access
  logic        wr_ok;               // Write lane 0 is enabled

  // Active selection and outputs
  logic [2:0]  sel;                 // Synchronised pin index
  logic [31:0] word0;
  logic [31:0] word1;
  logic [31:0] word_act;
  logic [11:0] n_w;
  logic [8:0]  r_w;
  logic [5:0]  q_w;
  logic [2:0]  p_w;
  logic [1:0]  band_w;
  logic [2:0]  amt_w;
  logic [2:0]  spread_field [8];    // Spread code of each setting
  logic        on_q;                // Spread enabled for active setting
  logic        choice_w;
  logic [2:0]  sel_q;               // Setting index shown in status
  logic [11:0] n_q;
  logic [8:0]  r_q;
  logic [5:0]  q_q;
  logic [2:0]  p_q;
  logic [1:0]  band_q;
  logic [2:0]  amt_q;
  logic [7:0]  hund_q;
  logic        choice_q;

  // True for an index inside the set zero word
  function automatic logic in_set0(input logic [7:0] i);
    return i >= synth_pll_cfg_pkg::IDX_B_SET0_BYTE0 &&
           i <= synth_pll_cfg_pkg::IDX_B_SET0_BYTE3;
  endfunction

  // True for an index inside the set one word
  function automatic logic in_set1(input logic [7:0] i);
    return i >= synth_pll_cfg_pkg::IDX_B_SET1_BYTE0 &&
           i <= synth_pll_cfg_pkg::IDX_B_SET1_BYTE3;
  endfunction

  // Pins come from outside the clock domain; a pin that moves while
  // sampled could leave the index half old and half new, so only the
  // second stage feeds the selection logic and the status read
  // A pin change reaches the outputs three edges later
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .pin_i  ({CTRL_SELECT_PIN2_I, CTRL_SELECT_PIN1_I, CTRL_SELECT_PIN0_I}),
    .sync_o (sel)
  );

  // Packed words, byte at the lowest index is most significant
  // The split into fields does not care how the host grouped its
  // writes, so a half-written word is visible until the last byte
  assign word0 = {set0_q[0], set0_q[1], set0_q[2], set0_q[3]};
  assign word1 = {set1_q[0], set1_q[1], set1_q[2], set1_q[3]};

  // Setting x picks the spread field and the set choice
  assign choice_w = freq_sel_q[sel];
  // One 3-bit spread field per setting, setting 7 at the top of 30h
  for (genvar s = 0; s < 8; s++) begin : g_spread
    assign spread_field[s] = spread_q[3*s +: 3];
  end
  assign amt_w    = spread_field[sel];
  assign word_act = choice_w ? word1 : word0;

  // Field split of the active word
  word_unpack u_word_unpack (
    .word_i           (word_act),
    .feedback_count_o (n_w),
    .remainder_o      (r_w),
    .quotient_o       (q_w),
    .prescale_o       (p_w),
    .osc_band_o       (band_w)
  );

  // Word index of the access; the two low address bits are ignored
  // and lane 0 alone carries the register byte
  assign idx   = AVS_ADDRESS_I[9:2];
  assign wr_ok = AVS_BYTEENABLE_I[0];

  // Bus and register next values
  always_comb begin
    state_d     = state_q;
    rdata_d     = rdata_q;
    wait_d      = wait_q;
    set0_d      = set0_q;
    set1_d      = set1_q;
    spread_d    = spread_q;
    freq_sel_d  = freq_sel_q;
    direction_d = direction_q;
    case (state_q)
      // Take a request, answer one cycle later
      synth_pll_cfg_pkg::BUS_IDLE: begin
        if (AVS_READ_I || AVS_WRITE_I) begin
          state_d = synth_pll_cfg_pkg::BUS_ACK;
          wait_d  = 1'b0;
          if (AVS_READ_I) begin
            // Read decode; only a read replaces the held read data
            rdata_d = synth_pll_cfg_pkg::UNMAPPED_DATA;
            if (in_set0(idx)) begin
              // Set zero word byte
              rdata_d[7:0] = set0_q[idx[1:0]];
            end else if (in_set1(idx)) begin
              // Set one word byte
              rdata_d[7:0] = set1_q[idx[1:0]];
            end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD0) begin
              // Settings 7 and 6, top two bits of 5
              rdata_d[7:0] = spread_q[23:16];
            end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD1) begin
              // Low bit of 5, settings 4 and 3, top bit of 2
              rdata_d[7:0] = spread_q[15:8];
            end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD2) begin
              // Low bits of 2, settings 1 and 0
              rdata_d[7:0] = spread_q[7:0];
            end else if (idx == synth_pll_cfg_pkg::IDX_C_FREQ_SEL) begin
              // Set choice bit per setting
              rdata_d[7:0] = freq_sel_q;
            end else if (idx == synth_pll_cfg_pkg::IDX_C_DIRECTION) begin
              // Direction in bit 0, rest reads zero
              rdata_d[0] = direction_q;
            end else if (idx == synth_pll_cfg_pkg::IDX_STATUS) begin
              // Status: active spread code, set choice, setting index
              rdata_d[7:0] = {1'b0, amt_q, choice_q, sel_q};
            end
          end
        end
      end
      // Release waitrequest for one cycle, then re-arm; the master
      // still holds its request here, so a write lands at the edge
      // at which it sees waitrequest low and at no earlier edge
      synth_pll_cfg_pkg::BUS_ACK: begin
        state_d = synth_pll_cfg_pkg::BUS_IDLE;
        wait_d  = 1'b1;
        if (AVS_WRITE_I && wr_ok) begin
          // Write decode, unmapped and read-only indices ignored
          if (in_set0(idx)) begin
            // Set zero word byte, most significant byte at 28h
            set0_d[idx[1:0]] = AVS_WRITEDATA_I[7:0];
          end else if (in_set1(idx)) begin
            // Set one word byte, band in the last byte
            set1_d[idx[1:0]] = AVS_WRITEDATA_I[7:0];
          end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD0) begin
            // Settings 7 and 6, top two bits of 5
            spread_d[23:16] = AVS_WRITEDATA_I[7:0];
          end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD1) begin
            // Low bit of 5, settings 4 and 3, top bit of 2
            spread_d[15:8] = AVS_WRITEDATA_I[7:0];
          end else if (idx == synth_pll_cfg_pkg::IDX_C_SPREAD2) begin
            // Low bits of 2, settings 1 and 0
            spread_d[7:0] = AVS_WRITEDATA_I[7:0];
          end else if (idx == synth_pll_cfg_pkg::IDX_C_FREQ_SEL) begin
            // One set choice bit per setting
            freq_sel_d = AVS_WRITEDATA_I[7:0];
          end else if (idx == synth_pll_cfg_pkg::IDX_C_DIRECTION) begin
            // Direction in bit 0, other bits dropped
            direction_d = AVS_WRITEDATA_I[0];
          end
        end
      end
      // Unused encoding: back to idle with waitrequest high
      default: begin
        state_d = synth_pll_cfg_pkg::BUS_IDLE;
        wait_d  = 1'b1;
      end
    endcase
  end

  // Bus and register storage; reset restores the default words so
  // the second PLL comes up on a known ratio whatever the pins say
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_q     <= synth_pll_cfg_pkg::BUS_IDLE;
      rdata_q     <= synth_pll_cfg_pkg::UNMAPPED_DATA;
      wait_q      <= 1'b1;
      // Default words: N, R, Q, P and band
      set0_q[0]   <= synth_pll_cfg_pkg::N_RESET[11:4];
      set0_q[1]   <= {synth_pll_cfg_pkg::N_RESET[3:0],
                      synth_pll_cfg_pkg::R_RESET[8:5]};
      set0_q[2]   <= {synth_pll_cfg_pkg::R_RESET[4:0],
                      synth_pll_cfg_pkg::Q_RESET[5:3]};
      set0_q[3]   <= {synth_pll_cfg_pkg::Q_RESET[2:0],
                      synth_pll_cfg_pkg::P_RESET,
                      synth_pll_cfg_pkg::BAND_RESET};
      // Set one starts from the same defaults as set zero
      set1_q[0]   <= synth_pll_cfg_pkg::N_RESET[11:4];
      set1_q[1]   <= {synth_pll_cfg_pkg::N_RESET[3:0],
                      synth_pll_cfg_pkg::R_RESET[8:5]};
      set1_q[2]   <= {synth_pll_cfg_pkg::R_RESET[4:0],
                      synth_pll_cfg_pkg::Q_RESET[5:3]};
      set1_q[3]   <= {synth_pll_cfg_pkg::Q_RESET[2:0],
                      synth_pll_cfg_pkg::P_RESET,
                      synth_pll_cfg_pkg::BAND_RESET};
      spread_q    <= {3{synth_pll_cfg_pkg::BYTE_RESET}};
      freq_sel_q  <= synth_pll_cfg_pkg::BYTE_RESET;
      direction_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      rdata_q     <= rdata_d;
      wait_q      <= wait_d;
      set0_q      <= set0_d;
      set1_q      <= set1_d;
      spread_q    <= spread_d;
      freq_sel_q  <= freq_sel_d;
      direction_q <= direction_d;
    end
  end

  // Registered active configuration; one register stage keeps every
  // output glitch-free while the index or a word byte changes
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      sel_q    <= 3'h0;
      n_q      <= synth_pll_cfg_pkg::N_RESET;
      r_q      <= synth_pll_cfg_pkg::R_RESET;
      q_q      <= synth_pll_cfg_pkg::Q_RESET;
      p_q      <= synth_pll_cfg_pkg::P_RESET;
      band_q   <= synth_pll_cfg_pkg::BAND_RESET;
      amt_q    <= synth_pll_cfg_pkg::SPREAD_OFF;
      hund_q   <= 8'h00;
      choice_q <= 1'b0;
      on_q     <= 1'b0;
    end else begin
      sel_q    <= sel;
      n_q      <= n_w;
      r_q      <= r_w;
      q_q      <= q_w;
      p_q      <= p_w;
      band_q   <= band_w;
      amt_q    <= amt_w;
      hund_q   <= synth_pll_cfg_pkg::spread_hundredths(amt_w);
      choice_q <= choice_w;
      on_q     <= (amt_w != synth_pll_cfg_pkg::SPREAD_OFF);
    end
  end

  // Outputs straight from flip-flops
  // No output is decoded after its register
  assign AVS_READDATA_O              = rdata_q;
  assign AVS_WAITREQUEST_O           = wait_q;
  assign SYNTH_B_FEEDBACK_COUNT_O    = n_q;
  assign SYNTH_B_REMAINDER_O         = r_q;
  assign SYNTH_B_QUOTIENT_O          = q_q;
  assign SYNTH_B_PRESCALE_O          = p_q;
  assign SYNTH_B_OSC_BAND_O          = band_q;
  assign SYNTH_C_SPREAD_AMOUNT_O     = amt_q;
  assign SYNTH_C_SPREAD_HUNDREDTHS_O = hund_q;
  assign SYNTH_C_SPREAD_ON_O         = on_q;
  assign SYNTH_C_SPREAD_DIRECTION_O  = direction_q;
  assign SYNTH_C_FREQ_CHOICE_O       = choice_q;

endmodule

// [tb/synth_pll_config_props.sv]
// Port checks for the PLL configuration register bank
`timescale 1ns/1ps
module synth_pll_config_props (
  // Clock and reset
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  // Register bus
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // Select pins
  input wire logic        CTRL_SELECT_PIN0_I,
  input wire logic        CTRL_SELECT_PIN1_I,
  input wire logic        CTRL_SELECT_PIN2_I,
  // Active configuration
  input wire logic [11:0] SYNTH_B_FEEDBACK_COUNT_O,
  input wire logic [5:0]  SYNTH_B_QUOTIENT_O,
  input wire logic [2:0]  SYNTH_B_PRESCALE_O,
  input wire logic [1:0]  SYNTH_B_OSC_BAND_O,
  input wire logic [2:0]  SYNTH_C_SPREAD_AMOUNT_O,
  input wire logic [7:0]  SYNTH_C_SPREAD_HUNDREDTHS_O,
  input wire logic        SYNTH_C_SPREAD_ON_O,
  input wire logic        SYNTH_C_FREQ_CHOICE_O
);
  // Spread amount in hundredths of a percent, by code
  localparam logic [7:0] HUND [8] = '{8'h00, 8'h19, 8'h32, 8'h4b,
                                      8'h64, 8'h7d, 8'h96, 8'hc8};
  logic [2:0] quiet_q, quiet_d; // Cycles since a write or pin change
  logic [2:0] pins_q;           // Pin levels at the last edge
  logic [2:0] pins;             // Pin levels now
  assign pins = {CTRL_SELECT_PIN2_I, CTRL_SELECT_PIN1_I,
                 CTRL_SELECT_PIN0_I};
  // Saturating count, cleared by reset, any write or a pin change
  always_comb begin
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if (RST_I || AVS_WRITE_I || pins != pins_q) quiet_d = 3'h0;
  end
  // Registers of the count and the last pin levels
  always_ff @(posedge CLOCK_I) begin
    quiet_q <= quiet_d;
    pins_q  <= pins;
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  chk_wait_one_cycle: assert property (
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("wait low twice");
  chk_take_answer: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("request not answered");
  chk_no_idle_answer: assert property (
    !AVS_READ_I && !AVS_WRITE_I && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("answer without request");
  chk_upper_zero: assert property (
    AVS_READDATA_O[31:8] == 24'h00_0000) else $error("read data too wide");
  chk_rdata_holds: assert property (
    AVS_WAITREQUEST_O && !AVS_READ_I |=> $stable(AVS_READDATA_O))
    else $error("read data moved");
  chk_spread_on: assert property (
    SYNTH_C_SPREAD_ON_O == (SYNTH_C_SPREAD_AMOUNT_O != 3'h0))
    else $error("spread enable wrong");
  chk_spread_amount: assert property (
    $stable(SYNTH_C_SPREAD_AMOUNT_O) |->
      SYNTH_C_SPREAD_HUNDREDTHS_O == HUND[SYNTH_C_SPREAD_AMOUNT_O])
    else $error("spread hundredths wrong");
  chk_reset_values: assert property (
    $past(RST_I) |-> SYNTH_B_FEEDBACK_COUNT_O == 12'h004 &&
      SYNTH_B_QUOTIENT_O == 6'h10 && SYNTH_B_PRESCALE_O == 3'h2 &&
      SYNTH_B_OSC_BAND_O == 2'h0 && !SYNTH_C_FREQ_CHOICE_O &&
      SYNTH_C_SPREAD_AMOUNT_O == 3'h0 && AVS_WAITREQUEST_O)
    else $error("reset values wrong");
  chk_quiet_stable: assert property (
    quiet_q >= 3'h4 |-> $stable(SYNTH_B_FEEDBACK_COUNT_O) &&
      $stable(SYNTH_B_OSC_BAND_O) && $stable(SYNTH_C_FREQ_CHOICE_O) &&
      $stable(SYNTH_C_SPREAD_AMOUNT_O)) else $error("output moved alone");
endmodule

// [tb/ctrl_pin_host.sv]
// Control-pin side of the bank: drives the three select pins
`timescale 1ns/1ps
module ctrl_pin_host (
  // Clock
  input  wire logic       clk_i,
  // Setting index wanted by the bench
  input  wire logic [2:0] setting_i,
  // Pin levels
  output logic            pin0_o,
  output logic            pin1_o,
  output logic            pin2_o
);
  // Pins follow the wanted index after each edge, bit 0 on pin 0
  always_ff @(posedge clk_i) begin
    {pin2_o, pin1_o, pin0_o} <= setting_i;
  end
endmodule

// [tb/synth_pll_config_regs_bench.sv]
// Self-checking bench for the PLL configuration register bank
`timescale 1ns/1ps
module synth_pll_config_regs_bench;
  localparam logic [7:0] HUND [8] = '{8'h00, 8'h19, 8'h32, 8'h4b,
                                      8'h64, 8'h7d, 8'h96, 8'hc8};
  localparam logic [7:0] RSTB [4] = '{8'h00, 8'h40, 8'h02, 8'h08};
  logic        clk = 1'b0;             // Bus clock
  logic        rst = 1'b1;             // Synchronous reset
  logic [9:0]  address = 10'h000;      // Byte address
  logic        rd = 1'b0;              // Read request
  logic        wr = 1'b0;              // Write request
  logic [31:0] wdata = 32'h0000_0000;  // Write data
  logic [3:0]  be = 4'hf;              // Byte enables
  logic [2:0]  setting = 3'h0;         // Wanted control setting
  logic [31:0] rdata;                  // Read data
  logic        waitreq;                // Bus wait
  logic        p0, p1, p2;             // Select pins
  logic [11:0] fb;                     // Active outputs
  logic [8:0]  rem;
  logic [5:0]  quo;
  logic [2:0]  pre, amt;
  logic [1:0]  band;
  logic [7:0]  hund;
  logic        on, dir, choice;
  logic [31:0] exp_q[$];               // Expected read data
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] word [2];               // Words of set zero and one
  logic [31:0] sel;                    // Word of the active set
  logic [23:0] spread;                 // Spread vector 30h..32h
  logic [7:0]  fsel;                   // Frequency choice byte
  logic [2:0]  r;                      // Random code offset
  always #25 clk = ~clk;
  synth_pll_config_regs uut (.CLOCK_I(clk), .RST_I(rst),
    .AVS_ADDRESS_I(address), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .CTRL_SELECT_PIN0_I(p0), .CTRL_SELECT_PIN1_I(p1),
    .CTRL_SELECT_PIN2_I(p2), .SYNTH_B_FEEDBACK_COUNT_O(fb),
    .SYNTH_B_REMAINDER_O(rem), .SYNTH_B_QUOTIENT_O(quo),
    .SYNTH_B_PRESCALE_O(pre), .SYNTH_B_OSC_BAND_O(band),
    .SYNTH_C_SPREAD_AMOUNT_O(amt), .SYNTH_C_SPREAD_HUNDREDTHS_O(hund),
    .SYNTH_C_SPREAD_ON_O(on), .SYNTH_C_SPREAD_DIRECTION_O(dir),
    .SYNTH_C_FREQ_CHOICE_O(choice));
  ctrl_pin_host pins (.clk_i(clk), .setting_i(setting), .pin0_o(p0),
    .pin1_o(p1), .pin2_o(p2));
  // Compares one value and counts it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] en);
    @(posedge clk);
    address <= {idx, 2'b00};
    wdata   <= {24'($urandom), d};
    be      <= en;
    rd      <= !w;
    wr      <= w;
    do @(posedge clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Read with its expected byte noted first
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask
  // Write, kept below the safe limit, then read back
  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
    rd_reg(idx, d);
  endtask
  // Watches read answers and the run length
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0 && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("wrong value at %0t: run timed out", $time);
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h3df3c012));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset contents of the bank
    for (int i = 0; i < 12; i++)
      rd_reg(8'(8'h28 + i), (i < 8) ? RSTB[i % 4] : 8'h00);
    rd_reg(8'h36, 8'h00);
    // Random words, spread and choices, then every setting in turn
    for (int pass = 0; pass < 4; pass++) begin
      for (int s = 0; s < 2; s++) begin
        word[s] = $urandom;
        word[s][1:0] = 2'(pass + 3 * s);
        for (int b = 0; b < 4; b++)
          wr_rd(8'(8'h28 + 4 * s + b), word[s][31-8*b -: 8]);
      end
      r = 3'($urandom);
      for (int x = 0; x < 8; x++) spread[3*x +: 3] = 3'(x) + r;
      fsel = 8'($urandom);
      for (int b = 0; b < 3; b++) wr_rd(8'(8'h30 + b), spread[23-8*b -: 8]);
      wr_rd(8'h33, fsel);
      wr_rd(8'h36, {7'h00, pass[0]});
      for (int x = 0; x < 8; x++) begin
        setting <= 3'(x);
        repeat (5) @(posedge clk);
        sel = word[fsel[x]];
        check(fb, sel[31:20]);
        check(rem, sel[19:11]);
        check(quo, sel[10:5]);
        check(pre, sel[4:2]);
        check(band, sel[1:0]);
        check(choice, fsel[x]);
        check(amt, spread[3*x +: 3]);
        check(hund, HUND[spread[3*x +: 3]]);
        check(on, spread[3*x +: 3] != 3'h0);
        check(dir, pass[0]);
      end
    end
    // Refused writes: byte 0 disabled, read-only status, unmapped place
    bus(1'b1, 8'h28, ~word[0][31:24], 4'he);
    rd_reg(8'h28, word[0][31:24]);
    bus(1'b1, 8'h3f, 8'hff, 4'hf);
    rd_reg(8'h3f, {1'b0, spread[23:21], fsel[7], 3'h7});
    bus(1'b1, 8'h20, 8'h5a, 4'hf);
    rd_reg(8'h20, 8'h00);
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h2f, 8'h08);
    check(fb, 32'h0000_0004);
    finish_test();
  end
endmodule
bind synth_pll_config_regs synth_pll_config_props chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .CTRL_SELECT_PIN0_I(CTRL_SELECT_PIN0_I),
  .CTRL_SELECT_PIN1_I(CTRL_SELECT_PIN1_I),
  .CTRL_SELECT_PIN2_I(CTRL_SELECT_PIN2_I),
  .SYNTH_B_FEEDBACK_COUNT_O(SYNTH_B_FEEDBACK_COUNT_O),
  .SYNTH_B_QUOTIENT_O(SYNTH_B_QUOTIENT_O),
  .SYNTH_B_PRESCALE_O(SYNTH_B_PRESCALE_O),
  .SYNTH_B_OSC_BAND_O(SYNTH_B_OSC_BAND_O),
  .SYNTH_C_SPREAD_AMOUNT_O(SYNTH_C_SPREAD_AMOUNT_O),
  .SYNTH_C_SPREAD_HUNDREDTHS_O(SYNTH_C_SPREAD_HUNDREDTHS_O),
  .SYNTH_C_SPREAD_ON_O(SYNTH_C_SPREAD_ON_O),
  .SYNTH_C_FREQ_CHOICE_O(SYNTH_C_FREQ_CHOICE_O));
